// ---- pkg/ioxp_pkg.sv ----
`default_nettype none
package ioxp_pkg;
  // Fixed upper nibble of the slave address byte
  localparam logic [3:0] ADDR_FIXED = 4'h4;
  // Command byte codes, low three bits select a register
  localparam logic [2:0] CMD_IN_A = 3'h0;
  localparam logic [2:0] CMD_IN_B = 3'h1;
  localparam logic [2:0] CMD_OUT_A = 3'h2;
  localparam logic [2:0] CMD_OUT_B = 3'h3;
  localparam logic [2:0] CMD_POL_A = 3'h4;
  localparam logic [2:0] CMD_POL_B = 3'h5;
  localparam logic [2:0] CMD_CFG_A = 3'h6;
  localparam logic [2:0] CMD_CFG_B = 3'h7;
  // Reset values and last bit index
  localparam logic [7:0] OUT_RST = 8'hff;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'hff;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Bus engine states
  typedef enum logic [6:0] {
    IOXP_IDLE = 7'h01,
    IOXP_ADDR = 7'h02,
    IOXP_AACK = 7'h04,
    IOXP_WBYTE = 7'h08,
    IOXP_WACK = 7'h10,
    IOXP_RBYTE = 7'h20,
    IOXP_RACK = 7'h40
  } ioxp_state_t;
endpackage : ioxp_pkg
`default_nettype wire

// ---- verilog/ioxp_top.sv ----
`default_nettype none
module ioxp_top #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic addr_sel_bit0_in,
  input wire logic addr_sel_bit1_in,
  input wire logic addr_sel_bit2_in,
  input wire logic [WIDTH-1:0] port_pin_in,
  output logic [WIDTH-1:0] port_pin_out,
  output logic [WIDTH-1:0] port_oe_n_out,
  output logic int_n_out,
  output logic int_oe_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers: the first stage feeds only the second
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic [WIDTH-1:0] pin_meta_ff;
  logic [WIDTH-1:0] pin_sync_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end

  // Port pins are asynchronous to the system clock
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= port_pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];
  assign scl_rise = scl_s && !scl_prev_ff;
  assign scl_fall = !scl_s && scl_prev_ff;
  assign start_det = scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
  assign stop_det = scl_s && scl_prev_ff && !sda_prev_ff && sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Bus engine
  ioxp_pkg::ioxp_state_t state_ff;
  ioxp_pkg::ioxp_state_t nxt_state;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic rw_ff;
  logic first_wbyte_ff;
  logic [2:0] cmd_ff;
  logic sda_low_ff;
  logic [7:0] tx_ff;

  // Address straps are pins too; a strap moved live must not split one address compare
  logic [2:0] sel_meta_ff;
  logic [2:0] sel_sync_ff;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sel_meta_ff <= '0;
      sel_sync_ff <= '0;
    end else begin
      sel_meta_ff <= {addr_sel_bit2_in, addr_sel_bit1_in, addr_sel_bit0_in};
      sel_sync_ff <= sel_meta_ff;
    end
  end

  logic [6:0] my_addr;
  logic [7:0] rx_byte;
  assign my_addr = {ioxp_pkg::ADDR_FIXED, sel_sync_ff};
  assign rx_byte = {shift_ff[6:0], sda_s};

  // Byte complete on the eighth SCL rise
  logic byte_done;
  assign byte_done = scl_rise && (bit_cnt_ff == ioxp_pkg::BIT_LAST);

  // Next state; START from anywhere restarts, STOP from anywhere idles
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ioxp_pkg::IOXP_IDLE: nxt_state = ioxp_pkg::IOXP_IDLE;
      ioxp_pkg::IOXP_ADDR: begin
        if (byte_done) begin
          nxt_state = (rx_byte[7:1] == my_addr) ? ioxp_pkg::IOXP_AACK : ioxp_pkg::IOXP_IDLE;
        end
      end
      ioxp_pkg::IOXP_AACK: begin
        // First fall raises the ack, the next one ends its clock
        if (scl_fall && sda_low_ff) begin
          nxt_state = rw_ff ? ioxp_pkg::IOXP_RBYTE : ioxp_pkg::IOXP_WBYTE;
        end
      end
      ioxp_pkg::IOXP_WBYTE: begin
        if (byte_done) begin
          nxt_state = ioxp_pkg::IOXP_WACK;
        end
      end
      ioxp_pkg::IOXP_WACK: begin
        if (scl_fall && sda_low_ff) begin
          nxt_state = ioxp_pkg::IOXP_WBYTE;
        end
      end
      ioxp_pkg::IOXP_RBYTE: begin
        if (scl_fall && bit_cnt_ff == ioxp_pkg::BIT_LAST) begin
          nxt_state = ioxp_pkg::IOXP_RACK;
        end
      end
      ioxp_pkg::IOXP_RACK: begin
        if (scl_rise) begin
          nxt_state = sda_s ? ioxp_pkg::IOXP_IDLE : ioxp_pkg::IOXP_RACK; // Master NACK ends the read
        end else if (scl_fall) begin
          nxt_state = ioxp_pkg::IOXP_RBYTE;
        end
      end
      default: nxt_state = ioxp_pkg::IOXP_IDLE;
    endcase
    if (start_det) begin
      nxt_state = ioxp_pkg::IOXP_ADDR;
    end else if (stop_det) begin
      nxt_state = ioxp_pkg::IOXP_IDLE;
    end
  end

  // the reset input returns the engine to IDLE; START and STOP act through nxt_state
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= ioxp_pkg::IOXP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Bit counter and receive shifter; counts reset on every state change
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_cnt_ff <= '0;
      shift_ff <= '0;
    end else if (nxt_state != state_ff) begin
      bit_cnt_ff <= '0;
    end else if (state_ff == ioxp_pkg::IOXP_RBYTE && scl_fall) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end else if (scl_rise && state_ff != ioxp_pkg::IOXP_RBYTE) begin // Transmit counts falls only
      shift_ff <= rx_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  // Direction flag and first-byte marker of a write
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rw_ff <= 1'b0;
      first_wbyte_ff <= 1'b0;
    end else if (state_ff == ioxp_pkg::IOXP_ADDR && byte_done) begin
      rw_ff <= rx_byte[0];
      first_wbyte_ff <= 1'b1;
    end else if (state_ff == ioxp_pkg::IOXP_WBYTE && byte_done) begin
      first_wbyte_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] pol_ff;
  logic [WIDTH-1:0] cfg_ff;
  logic [WIDTH-1:0] in_latch_ff;
  logic wr_stb;
  logic rd_ack_rise;
  logic [2:0] rd_sel;
  assign wr_stb = state_ff == ioxp_pkg::IOXP_WBYTE && byte_done && !first_wbyte_ff;
  // Acknowledge clock rise that precedes a data byte: after address ack or master ACK
  assign rd_ack_rise = scl_rise && rw_ff &&
    ((state_ff == ioxp_pkg::IOXP_AACK) || (state_ff == ioxp_pkg::IOXP_RACK && !sda_s));
  // A master ACK moves to the pair partner before its byte is captured
  assign rd_sel = (state_ff == ioxp_pkg::IOXP_RACK) ? {cmd_ff[2:1], ~cmd_ff[0]} : cmd_ff;

  // Command pointer; auto-alternates within the pair after every written data byte and every master-ACKed read byte
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_ff <= ioxp_pkg::CMD_IN_A;
    end else if (state_ff == ioxp_pkg::IOXP_WBYTE && byte_done) begin
      cmd_ff <= first_wbyte_ff ? rx_byte[2:0] : {cmd_ff[2:1], ~cmd_ff[0]};
    end else if (rd_ack_rise && state_ff == ioxp_pkg::IOXP_RACK) begin
      cmd_ff <= rd_sel;
    end
  end

  // Writable registers; input registers ignore writes
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_ff <= {2{ioxp_pkg::OUT_RST}};
      pol_ff <= {2{ioxp_pkg::POL_RST}};
      cfg_ff <= {2{ioxp_pkg::CFG_RST}};
    end else if (wr_stb) begin
      case (cmd_ff)
        ioxp_pkg::CMD_OUT_A: out_ff[7:0] <= rx_byte;
        ioxp_pkg::CMD_OUT_B: out_ff[15:8] <= rx_byte;
        ioxp_pkg::CMD_POL_A: pol_ff[7:0] <= rx_byte;
        ioxp_pkg::CMD_POL_B: pol_ff[15:8] <= rx_byte;
        ioxp_pkg::CMD_CFG_A: cfg_ff[7:0] <= rx_byte;
        ioxp_pkg::CMD_CFG_B: cfg_ff[15:8] <= rx_byte;
        default: cfg_ff <= cfg_ff;
      endcase
    end
  end

  // Read mux, captured at the acknowledge rise
  logic [WIDTH-1:0] in_view;
  logic [7:0] rd_mux;
  assign in_view = pin_sync_ff ^ pol_ff;
  always_comb begin
    case (rd_sel)
      ioxp_pkg::CMD_IN_A: rd_mux = in_view[7:0];
      ioxp_pkg::CMD_IN_B: rd_mux = in_view[15:8];
      ioxp_pkg::CMD_OUT_A: rd_mux = out_ff[7:0];
      ioxp_pkg::CMD_OUT_B: rd_mux = out_ff[15:8];
      ioxp_pkg::CMD_POL_A: rd_mux = pol_ff[7:0];
      ioxp_pkg::CMD_POL_B: rd_mux = pol_ff[15:8];
      ioxp_pkg::CMD_CFG_A: rd_mux = cfg_ff[7:0];
      default: rd_mux = cfg_ff[15:8];
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_ff <= '0;
    end else if (rd_ack_rise) begin
      tx_ff <= rd_mux;
    end else if (state_ff == ioxp_pkg::IOXP_RBYTE && scl_fall) begin
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SDA drive: ack low in AACK/WACK, data MSB first in RBYTE, released elsewhere
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sda_low_ff <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_low_ff <= 1'b0;
    end else if (scl_fall) begin
      case (nxt_state)
        ioxp_pkg::IOXP_AACK: sda_low_ff <= 1'b1;
        ioxp_pkg::IOXP_WACK: sda_low_ff <= 1'b1;
        ioxp_pkg::IOXP_RBYTE: sda_low_ff <= (state_ff == ioxp_pkg::IOXP_RBYTE) ? !tx_ff[6] : !tx_ff[7];
        default: sda_low_ff <= 1'b0;
      endcase
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe_n_out = !sda_low_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Port pins: config bit 1 means input, outputs drive from the output latch
  assign port_pin_out = out_ff;
  assign port_oe_n_out = cfg_ff;

  // Latched input snapshot per port, refreshed at a read acknowledge of that port
  logic rd_port_a;
  logic rd_port_b;
  assign rd_port_a = rd_ack_rise && rd_sel == ioxp_pkg::CMD_IN_A;
  assign rd_port_b = rd_ack_rise && rd_sel == ioxp_pkg::CMD_IN_B;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_latch_ff <= '0;
    end else begin
      if (rd_port_a) begin
        in_latch_ff[7:0] <= pin_sync_ff[7:0];
      end
      if (rd_port_b) begin
        in_latch_ff[15:8] <= pin_sync_ff[15:8];
      end
    end
  end

  // Mismatch on input-mode pins drives the open-drain interrupt; a pin back at its
  // latched level drops its own term, and a change inside the ack pulse can be absorbed
  logic [WIDTH-1:0] diff;
  logic irq_ff;
  assign diff = (pin_sync_ff ^ in_latch_ff) & cfg_ff;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |diff;
    end
  end
  assign int_n_out = 1'b0;
  assign int_oe_n_out = !irq_ff;

endmodule : ioxp_top
`default_nettype wire

// ---- bench/ioxp_asserts.sv ----
`default_nettype none
module ioxp_asserts #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic [WIDTH-1:0] port_pin_in,
  input wire logic [WIDTH-1:0] port_pin_out,
  input wire logic [WIDTH-1:0] port_oe_n_out,
  input wire logic int_n_out,
  input wire logic int_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] quiet_ff;
  logic [3:0] rise_ff;
  logic scl_q_ff;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // Cycles since an input-mode pin or the direction moved; saturates
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      quiet_ff <= 4'h0;
    end else if ($changed(port_pin_in & port_oe_n_out) || $changed(port_oe_n_out)) begin
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'hf) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end
  // Cycles since SCL rose; register updates and read clears follow it
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_q_ff <= 1'b1;
      rise_ff <= 4'hf;
    end else begin
      scl_q_ff <= scl_in;
      if (scl_in && !scl_q_ff) rise_ff <= 4'h0;
      else if (rise_ff != 4'hf) rise_ff <= rise_ff + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_int_fall; int_oe_n_out ##1 !int_oe_n_out; endsequence
  sequence s_int_rise; !int_oe_n_out ##1 int_oe_n_out; endsequence
  property p_rst_cfg; $rose(nrst_in) |-> port_oe_n_out == '1; endproperty
  a_rst_cfg: assert property (p_rst_cfg) else $error("pins not inputs");
  property p_rst_out; $rose(nrst_in) |-> port_pin_out == '1; endproperty
  a_rst_out: assert property (p_rst_out) else $error("output latch not set");
  property p_rst_idle; $rose(nrst_in) |-> sda_oe_n_out && int_oe_n_out; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("lines driven at reset");
  property p_const_low; sda_out == 1'b0 && int_n_out == 1'b0; endproperty
  a_const_low: assert property (p_const_low) else $error("open drain level high");
  property p_int_cause; s_int_fall |-> quiet_ff < 4'h8; endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt without cause");
  property p_int_clear; s_int_rise |-> quiet_ff < 4'h8 || rise_ff < 4'h8; endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt cleared alone");
  property p_reg_upd; $changed(port_pin_out) || $changed(port_oe_n_out) |-> rise_ff < 4'h8; endproperty
  a_reg_upd: assert property (p_reg_upd) else $error("register moved off bus");
  property p_sda_low; $changed(sda_oe_n_out) |-> !scl_in; endproperty
  a_sda_low: assert property (p_sda_low) else $error("SDA moved with SCL high");
endmodule : ioxp_asserts
bind ioxp_top ioxp_asserts #(.WIDTH(WIDTH)) u_asserts (
  .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_n_out(sda_oe_n_out), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
  .port_oe_n_out(port_oe_n_out), .int_n_out(int_n_out), .int_oe_n_out(int_oe_n_out)
);
`default_nettype wire

// ---- bench/ioxp_master.sv ----
`default_nettype none
module ioxp_master (
  output logic scl_out,
  output logic sda_drv_out,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic r;
  // Bus idles high; the clock stands still between frames
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  // Data moves mid-low and is sampled late in the high phase
  task automatic bit_io(input logic b, output logic q);
    sda_drv_out = b;
    #40 scl_out = 1'b1;
    #70 q = sda_in;
    #10 scl_out = 1'b0;
    #40;
  endtask : bit_io
  // Start or repeated start, only from an idle or owned bus
  task automatic start();
    sda_drv_out = 1'b1;
    #40 scl_out = 1'b1;
    #80 sda_drv_out = 1'b0;
    #80 scl_out = 1'b0;
    #40;
  endtask : start
  task automatic stop();
    sda_drv_out = 1'b0;
    #40 scl_out = 1'b1;
    #80 sda_drv_out = 1'b1;
    #80;
  endtask : stop
  // Byte out MSB first, then the slave's acknowledge slot
  task automatic wb(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wb
  // Byte in; the last one is refused so the slave lets go
  task automatic rb(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : rb
endmodule : ioxp_master
`default_nettype wire

// ---- bench/tb_ioxp_top.sv ----
`default_nettype none
module tb_ioxp_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] SEL = 3'h5;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [15:0] pins = 16'h0000;
  logic [15:0] pin_out, oe_n;
  logic sda_o, sda_oe_n, int_n, int_oe_n, scl, m_sda, k;
  logic [7:0] regs [8];
  logic [7:0] r0, r1;
  logic [31:0] seed = 32'h3f;
  int miscompares = 0;
  int samples_checked = 0;
  // Wired levels: SDA pull-up wins unless someone pulls low; port pins follow the output latch where enabled
  wire sda = m_sda & (sda_oe_n | sda_o);
  wire [15:0] lvl = (oe_n & pins) | (~oe_n & pin_out);
  ioxp_top dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .addr_sel_bit0_in(SEL[0]),
    .addr_sel_bit1_in(SEL[1]), .addr_sel_bit2_in(SEL[2]), .port_pin_in(lvl),
    .port_pin_out(pin_out), .port_oe_n_out(oe_n), .int_n_out(int_n), .int_oe_n_out(int_oe_n));
  ioxp_master mst (.scl_out(scl), .sda_drv_out(m_sda), .sda_in(sda));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  // Input ports report pin levels through the polarity mask
  function automatic logic [7:0] exp_reg(input logic [2:0] c);
    if (c < 3'h2) return (c[0] ? lvl[15:8] : lvl[7:0]) ^ regs[{2'h2, c[0]}];
    return regs[c];
  endfunction : exp_reg
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    samples_checked++;
    if (got !== want) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk
  task automatic wreg(input logic [2:0] c, input logic [7:0] a, input logic [7:0] b);
    mst.start();
    mst.wb({ioxp_pkg::ADDR_FIXED, SEL, 1'b0}, k);
    chk({15'h0, k}, 16'h1);
    mst.wb({5'h00, c}, k);
    mst.wb(a, k);
    mst.wb(b, k);
    mst.stop();
    if (c > 3'h1) begin
      regs[c] = a;
      regs[c ^ 3'h1] = b;
    end
  endtask : wreg
  task automatic rreg(input logic [2:0] c, input logic two);
    mst.start();
    mst.wb({ioxp_pkg::ADDR_FIXED, SEL, 1'b0}, k);
    mst.wb({5'h00, c}, k);
    mst.start();
    mst.wb({ioxp_pkg::ADDR_FIXED, SEL, 1'b1}, k);
    mst.rb(r0, !two);
    if (two) mst.rb(r1, 1'b1);
    mst.stop();
  endtask : rreg
  // Interrupt settles a few cycles after its cause
  task automatic wint(input logic e);
    repeat (6) @(negedge sys_clk_in);
    chk({15'h0, int_oe_n | int_n}, {15'h0, e});
  endtask : wint
  task automatic complete_run();
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////
  initial forever #10 sys_clk_in = ~sys_clk_in;
  // Whole run is some 16.5k cycles; this cuts a hung bus short
  initial begin
    #2000000;
    miscompares++;
    complete_run();
  end
  initial begin
    regs = '{8'h00, 8'h00, ioxp_pkg::OUT_RST, ioxp_pkg::OUT_RST, ioxp_pkg::POL_RST,
      ioxp_pkg::POL_RST, ioxp_pkg::CFG_RST, ioxp_pkg::CFG_RST};
    pins = {xs(), xs()};
    repeat (2) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    chk(oe_n, 16'hffff);
    // First pass reads reset values, later passes write then read back
    for (int it = 0; it < 3; it++) begin
      for (int c = 0; c < 8; c++) begin
        if (it > 0) wreg(3'(c), xs(), xs());
        pins = {xs(), xs()};
        rreg(3'(c), 1'b1);
        chk({r1, r0}, {exp_reg(3'(c ^ 1)), exp_reg(3'(c))});
      end
      chk(pin_out, {regs[3], regs[2]});
      chk(oe_n, {regs[7], regs[6]});
    end
    wreg(3'h6, 8'hff, 8'hff);
    rreg(3'h0, 1'b1);
    wint(1'b1);
    pins ^= 16'h0001;
    wint(1'b0);
    rreg(3'h1, 1'b0);
    wint(1'b0);
    mst.start();
    mst.wb({ioxp_pkg::ADDR_FIXED, ~SEL, 1'b0}, k);
    mst.stop();
    chk({15'h0, k}, 16'h0);
    wint(1'b0);
    rreg(3'h0, 1'b0);
    wint(1'b1);
    pins ^= 16'h0100;
    wint(1'b0);
    pins ^= 16'h0100;
    wint(1'b1);
    wreg(3'h6, 8'h00, 8'hff);
    wreg(3'h2, ~regs[2], regs[3]);
    pins ^= 16'h00ff;
    wint(1'b1);
    complete_run();
  end
endmodule : tb_ioxp_top
`default_nettype wire
